/* dv/wwd_tb.sv */
// Self-checking testbench of the window watchdog
`default_nettype none
module testbench
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } wwd_row_t;
  logic        hclk      = 1'h0;
  logic        hresetn   = 1'h0;
  logic        hsel      = 1'h0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0;
  logic        reset_ack = 1'h0;
  logic [2:0]  ins       = 3'h0;
  logic [1:0]  wk        = 2'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        reset_request;
  logic        irq;
  logic [31:0] q;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          n;
  // Register reads after reset, then writes read back
  wwd_row_t    tab [13] = '{
    '{1'h0, 32'h0C, 32'h0, 32'h0001FFFC}, '{1'h0, 32'h00, 32'h0, 32'h1},
    '{1'h0, 32'h04, 32'h0, 32'hFFFC}, '{1'h0, 32'h08, 32'h0, 32'h0},
    '{1'h0, 32'h10, 32'h0, 32'h0}, '{1'h0, 32'h14, 32'h0, 32'h0},
    '{1'h1, 32'h0C, 32'h0, 32'hFFFC}, '{1'h1, 32'h00, 32'hFFFFFFFF, 32'h3},
    '{1'h1, 32'h04, 32'h1234ABCD, 32'hABCD}, '{1'h1, 32'h08, 32'hFFFF0010, 32'h10},
    '{1'h1, 32'h18, 32'hFFFFFFFF, 32'h0}, '{1'h1, 32'h104, 32'hFFFFFFFF, 32'h0},
    '{1'h1, 32'h14, 32'hFFFFFFFF, 32'h3}};

  always #12.5 hclk = ~hclk;

  always @(posedge hclk)
  begin
    wk  <= wk + 2'h1;
    cyc <= cyc + 1;
  end

  wwd_top #(.DIV_HI(16)) dut (
    .hclk                         (hclk),
    .hresetn                      (hresetn),
    .hsel                         (hsel),
    .haddr                        (haddr),
    .htrans                       (htrans),
    .hwrite                       (hwrite),
    .hsize                        (3'h2),
    .hready                       (hreadyout),
    .hwdata                       (hwdata),
    .hrdata                       (hrdata),
    .hreadyout                    (hreadyout),
    .hresp                        (hresp),
    .wakeup_osc_clock             (wk[1]),
    .watchdog_service_instruction (ins[0]),
    .watchdog_off_instruction     (ins[1]),
    .watchdog_on_instruction      (ins[2]),
    .reset_ack                    (reset_ack),
    .reset_request                (reset_request),
    .irq                          (irq)
  );

  task finish_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task tmo(input logic [31:0] what);
    chk(what, 32'hFFFFFFFF);
    finish_test();
  endtask : tmo

  task rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
      tmo(32'h0);
  endtask : rdy

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk(hresp, 32'h0);
  endtask : bus

  task rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++)
    begin
      if (tab[i].w)
        bus(1'b1, tab[i].a, tab[i].d);
      bus(1'b0, tab[i].a, 32'h0);
      chk(q, tab[i].e);
    end
  endtask : rows

  task pulse(input logic [2:0] v);
    ins <= v;
    @(posedge hclk);
    ins <= 3'h0;
    @(posedge hclk);
  endtask : pulse

  task wait_req(input int lim);
    n = 0;
    while (reset_request !== 1'b1 && n < lim)
    begin
      @(posedge hclk);
      n++;
    end
    if (reset_request !== 1'b1)
      tmo(32'h1);
  endtask : wait_req

  task ack;
    reset_ack <= 1'b1;
    @(posedge hclk);
    reset_ack <= 1'b0;
    @(posedge hclk);
    chk(reset_request, 32'h0);
  endtask : ack

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rows(0, 5);
    wait_req(400);
    chk(cyc > 198 && cyc < 340, 32'h1);
    pulse(3'h2);
    chk(irq, 32'h0);
    pulse(3'h1);
    rows(6, 12);
    chk(irq, 32'h1);
    chk(reset_request, 32'h1);
    bus(1'b0, 32'h10, 32'h0);
    chk(q, 32'h1);
    chk(irq, 32'h0);
    ack();
    pulse(3'h1);
    bus(1'b0, 32'h0C, 32'h0);
    chk(q, 32'hABCD);
    pulse(3'h4);
    bus(1'b0, 32'h0C, 32'h0);
    chk(q[16], 32'h1);
    bus(1'b1, 32'h04, 32'h0100);
    bus(1'b1, 32'h08, 32'hFFFF);
    pulse(3'h1);
    chk(reset_request, 32'h1);
    bus(1'b0, 32'h0C, 32'h0);
    chk(q[15:8], 32'hAB);
    bus(1'b0, 32'h10, 32'h0);
    chk(q, 32'h2);
    ack();
    bus(1'b1, 32'h08, 32'h0);
    pulse(3'h1);
    bus(1'b0, 32'h0C, 32'h0);
    chk(q[16:8], 32'h101);
    // Reload all ones: overflows repeat at the divided tick rate
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, 32'h00, i ? 32'h0 : 32'h2);
      bus(1'b1, 32'h04, 32'hFFFF);
      pulse(3'h1);
      wait_req(300);
      ack();
      wait_req(300);
      chk(n, i ? 32'd14 : 32'd254);
      ack();
    end
    hresetn <= 1'b0;
    @(posedge hclk);
    chk(reset_request, 32'h0);
    chk(irq, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rows(0, 5);
    finish_test();
  end
endmodule : testbench
`default_nettype wire

/* hdl/wwd_pkg.sv */
// Constants, types and register map of the window watchdog
`default_nettype none
package wwd_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DIV_HI_DEFAULT = 16384;
  localparam int unsigned DIV_LO = 256;
  localparam int unsigned PRE_W = 14;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_WINDOW = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  // Control fields
  localparam int unsigned CTRL_CLKSEL_BIT = 0;
  localparam int unsigned CTRL_DIVSEL_BIT = 1;
  // Status and mask fields
  localparam int unsigned ST_OVF_BIT = 0;
  localparam int unsigned ST_WIN_BIT = 1;
  localparam int unsigned ST_W       = 2;
  // Count register fields
  localparam int unsigned CNT_RUN_BIT = 16;
  // Defaults: wake-up clock, divide by 16384, 4 ticks of 32.768 ms each
  localparam logic        CTRL_CLKSEL_RST = 1'b1;
  localparam logic        CTRL_DIVSEL_RST = 1'b0;
  localparam logic [15:0] RELOAD_RST      = 16'hFFFC;
  localparam logic [15:0] WINDOW_RST      = 16'h0000;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] CNT_ONE         = 16'h0001;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

  typedef enum logic {WWD_RUN, WWD_OFF} wwd_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } wwd_aphase_t;

  typedef struct packed {
    logic clk_sel;
    logic div_sel;
  } wwd_ctrl_t;
endpackage : wwd_pkg
`default_nettype wire

/* hdl/wwd_prescaler.sv */
// Tick prescaler of the window watchdog
`default_nettype none
module wwd_prescaler
  import wwd_pkg::*;
#(
  parameter int unsigned DIV_HI = DIV_HI_DEFAULT
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic src_pulse,
  input  wire logic div_sel,
  output logic      tick
);
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [PRE_W-1:0] last;
  logic             tick_next;
  logic             tick_reg;

  assign tick = tick_reg;

  always_comb
  begin
    last      = div_sel ? PRE_W'(DIV_LO - 1) : PRE_W'(DIV_HI - 1);
    pre_next  = pre_reg;
    tick_next = 1'b0;
    if (src_pulse)
    begin
      if (pre_reg >= last)
      begin
        pre_next  = '0;
        tick_next = 1'b1;
      end
      else
        pre_next = pre_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    tick |=> !tick)
    else $error("Prescaler ticked twice in a row");
endmodule : wwd_prescaler
`default_nettype wire

/* hdl/wwd_top.sv */
// Window watchdog with AHB-Lite register slave
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`default_nettype none
module wwd_top
  import wwd_pkg::*;
#(
  parameter int unsigned DIV_HI = DIV_HI_DEFAULT
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wakeup_osc_clock,
  input  wire logic        watchdog_service_instruction,
  input  wire logic        watchdog_off_instruction,
  input  wire logic        watchdog_on_instruction,
  input  wire logic        reset_ack,
  output logic             reset_request,
  output logic             irq
);
  wwd_aphase_t       ap_reg;
  wwd_aphase_t       ap_next;
  logic [31:0]       hrdata_reg;
  logic [31:0]       hrdata_next;
  wwd_ctrl_t         ctrl_reg;
  wwd_ctrl_t         ctrl_next;
  logic [CNT_W-1:0]  reload_reg;
  logic [CNT_W-1:0]  reload_next;
  logic [CNT_W-1:0]  window_reg;
  logic [CNT_W-1:0]  window_next;
  logic [ST_W-1:0]   status_reg;
  logic [ST_W-1:0]   status_next;
  logic [ST_W-1:0]   mask_reg;
  logic [ST_W-1:0]   mask_next;
  wwd_state_t        state_reg;
  wwd_state_t        state_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic              req_reg;
  logic              req_next;
  logic              wu_reg;
  logic              first_reg;
  logic              running;
  logic              tick;
  logic              src_pulse;
  logic              in_window;
  logic              ovf_evt;
  logic              win_evt;
  logic              good_srv;
  logic              addr_ok;
  logic              wr_en;
  logic              rd_status;

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_reg;
  assign reset_request = req_reg;
  assign irq           = |(status_reg & mask_reg);

  // Tick source: every system cycle or each wake-up clock rising edge
  assign src_pulse = ctrl_reg.clk_sel ? (wakeup_osc_clock & ~wu_reg) : 1'b1;

  wwd_prescaler #(
    .DIV_HI (DIV_HI)
  ) u_pre (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .src_pulse (src_pulse),
    .div_sel   (ctrl_reg.div_sel),
    .tick      (tick)
  );

  // Watchdog events
  assign running   = (state_reg == WWD_RUN);
  assign in_window = (count_reg < window_reg);
  assign win_evt   = running && watchdog_service_instruction && in_window;
  assign good_srv  = watchdog_service_instruction && !win_evt;
  assign ovf_evt   = running && tick && !good_srv && (count_reg == CNT_MAX);

  always_comb
  begin
    state_next = state_reg;
    if (watchdog_off_instruction)
      state_next = WWD_OFF;
    else if (watchdog_on_instruction)
      state_next = WWD_RUN;
  end

  always_comb
  begin
    count_next = count_reg;
    if (good_srv)
      count_next = reload_reg;
    else if (ovf_evt)
      count_next = reload_reg;
    else if (running && tick)
      count_next = count_reg + CNT_ONE;
  end

  always_comb
  begin
    req_next = req_reg;
    if (ovf_evt || win_evt)
      req_next = 1'b1;
    else if (reset_ack)
      req_next = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= WWD_RUN;
      count_reg <= RELOAD_RST;
      req_reg   <= 1'b0;
      wu_reg    <= 1'b1; // No false edge from a pin high at release
      first_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      req_reg   <= req_next;
      wu_reg    <= wakeup_osc_clock;
      first_reg <= 1'b0;
    end
  end

  // Bus slave
  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_en     = ap_reg.valid && ap_reg.write;
  assign rd_status = addr_ok && !hwrite && (haddr[7:0] == OFS_STATUS) && (haddr[31:8] == '0);

  always_comb
  begin
    ap_next       = '0;
    ap_next.valid = addr_ok;
    ap_next.write = hwrite;
    ap_next.addr  = haddr[7:0];
    hrdata_next   = '0;
    if (addr_ok && !hwrite && haddr[31:8] == '0)
    begin
      unique case (haddr[7:0])
        OFS_CTRL:
        begin
          hrdata_next[CTRL_CLKSEL_BIT] = ctrl_reg.clk_sel;
          hrdata_next[CTRL_DIVSEL_BIT] = ctrl_reg.div_sel;
        end
        OFS_RELOAD: hrdata_next[CNT_W-1:0] = reload_reg;
        OFS_WINDOW: hrdata_next[CNT_W-1:0] = window_reg;
        OFS_COUNT:
        begin
          hrdata_next[CNT_W-1:0]   = count_reg;
          hrdata_next[CNT_RUN_BIT] = running;
        end
        OFS_STATUS: hrdata_next[ST_W-1:0] = status_reg;
        OFS_MASK:   hrdata_next[ST_W-1:0] = mask_reg;
        default:    hrdata_next = '0;
      endcase
    end
    else
      ap_next.valid = addr_ok && (haddr[31:8] == '0);
  end

  always_comb
  begin
    ctrl_next   = ctrl_reg;
    reload_next = reload_reg;
    window_next = window_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    if (wr_en)
    begin
      unique case (ap_reg.addr)
        OFS_CTRL:
        begin
          ctrl_next.clk_sel = hwdata[CTRL_CLKSEL_BIT];
          ctrl_next.div_sel = hwdata[CTRL_DIVSEL_BIT];
        end
        OFS_RELOAD: reload_next = hwdata[CNT_W-1:0];
        OFS_WINDOW: window_next = hwdata[CNT_W-1:0];
        OFS_MASK:   mask_next   = hwdata[ST_W-1:0];
        default:    mask_next   = mask_reg;
      endcase
    end
    if (rd_status)
      status_next = '0;
    // Set wins over read clear
    if (ovf_evt)
      status_next[ST_OVF_BIT] = 1'b1;
    if (win_evt)
      status_next[ST_WIN_BIT] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_reg          <= '0;
      hrdata_reg      <= '0;
      ctrl_reg.clk_sel <= CTRL_CLKSEL_RST;
      ctrl_reg.div_sel <= CTRL_DIVSEL_RST;
      reload_reg      <= RELOAD_RST;
      window_reg      <= WINDOW_RST;
      status_reg      <= '0;
      mask_reg        <= '0;
    end
    else
    begin
      ap_reg          <= ap_next;
      hrdata_reg      <= hrdata_next;
      ctrl_reg        <= ctrl_next;
      reload_reg      <= reload_next;
      window_reg      <= window_next;
      status_reg      <= status_next;
      mask_reg        <= mask_next;
    end
  end

  // Checks
  sequence s_service_ok;
    watchdog_service_instruction && !(running && in_window);
  endsequence

  sequence s_early_service;
    running && watchdog_service_instruction && in_window;
  endsequence

  a_start_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
    first_reg |-> running)
    else $error("Watchdog not running after reset");

  a_off_stops: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_off_instruction |=> !running ##1
    (running || $past(watchdog_service_instruction) || !$changed(count_reg)))
    else $error("Off instruction did not stop the watchdog");

  a_on_starts: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_on_instruction && !watchdog_off_instruction |=> running)
    else $error("On instruction did not start the watchdog");

  a_overflow_req: assert property (@(posedge hclk) disable iff (!hresetn)
    running && tick && count_reg == CNT_MAX && !watchdog_service_instruction
    |=> reset_request && status_reg[ST_OVF_BIT])
    else $error("Overflow without reset request");

  a_window_req: assert property (@(posedge hclk) disable iff (!hresetn)
    s_early_service |=> reset_request && count_reg == $past(count_reg) + $past(CNT_W'(tick)))
    else $error("Early service reloaded or gave no request");

  a_service_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    s_service_ok |=> count_reg == $past(reload_reg))
    else $error("Service did not load the reload value");

  a_tick_counts: assert property (@(posedge hclk) disable iff (!hresetn)
    running && tick && count_reg != CNT_MAX && !watchdog_service_instruction
    |=> count_reg == $past(count_reg) + CNT_ONE)
    else $error("Counter did not step once on tick");

  a_req_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_request && !reset_ack |=> reset_request ##1 (reset_request || $past(reset_ack)))
    else $error("Reset request dropped before acknowledge");

  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(status_reg[ST_OVF_BIT]) && mask_reg[ST_OVF_BIT] |-> irq)
    else $error("Unmasked event left irq low");

  // Counter, status, request and read data checks
  a_stopped_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !running && !watchdog_service_instruction |=> count_reg == $past(count_reg))
    else $error("Stopped counter moved");

  a_ovf_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    running && tick && count_reg == CNT_MAX && !watchdog_service_instruction
    |=> count_reg == $past(reload_reg))
    else $error("Overflow did not restart from reload value");

  a_status_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_status |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("Status bit cleared without a read");

  a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status && !ovf_evt && !win_evt |=> status_reg == '0)
    else $error("Status read did not clear it");

  a_req_release: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_ack && !ovf_evt && !win_evt |=> !reset_request)
    else $error("Reset request stayed after acknowledge");

  a_hrdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !(addr_ok && !hwrite) |=> hrdata == '0)
    else $error("Read data not zero outside a data phase");
endmodule : wwd_top
`default_nettype wire
